// *** core/irq_unit_pkg.sv ***
// Constants, register map and types of the two-level interrupt unit
package irq_unit_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_VEC_CONFIG = 8'h00;
   localparam logic [7:0] OFF_VEC_BASE = 8'h04;
   localparam logic [7:0] OFF_TRIGGER_MODE = 8'h08;
   localparam logic [7:0] OFF_LEVEL_ASSIGN = 8'h0c;
   localparam logic [7:0] OFF_STATUS_WORD = 8'h10;
   localparam logic [7:0] OFF_LOW_LINK = 8'h14;
   localparam logic [7:0] OFF_MID_LINK = 8'h18;
   localparam logic [7:0] OFF_LOW_STATUS_SAVE = 8'h1c;
   localparam logic [7:0] OFF_MID_STATUS_SAVE = 8'h20;
   localparam logic [7:0] OFF_PENDING = 8'h24;
   // Status word bit positions
   localparam int LOW_SET_ENABLE_BIT = 1;
   localparam int MID_SET_ENABLE_BIT = 2;
   localparam int LOW_ACTIVE_BIT = 3;
   localparam int MID_ACTIVE_BIT = 4;
   // Configuration register fields
   localparam int CFG_VARIANT_BIT = 0;
   localparam int CFG_EXT_BIT = 1;
   localparam logic [31:0] CFG_BASE_MASK = 32'hffff_fc00;
   // Reset values
   localparam logic [31:0] RESET_STATUS_WORD = 32'h0000_0000;
   localparam logic [31:0] RESET_TRIGGER_MODE = 32'h0000_0000;
   localparam logic [31:0] RESET_LEVEL_32 = 32'h0000_0000;
   localparam logic [31:0] RESET_LEVEL_16 = 32'h0000_00c0;
   // Vector numbers and slot layout
   localparam logic [4:0] VEC_MEM_ERROR = 5'h01;
   localparam logic [4:0] VEC_INSTR_ERROR = 5'h02;
   localparam logic [4:0] TOP_LINE_16 = 5'h07;
   localparam logic [31:0] LINES_32 = 32'hffff_fff8;
   localparam logic [31:0] LINES_16 = 32'h0000_fff8;
   localparam logic [31:0] LINES_EXT = 32'hffff_0000;
   localparam int SLOT_SHIFT = 3;
   // Kind of entry chosen in a cycle
   typedef enum logic [2:0] {
      TAKE_NONE = 3'b000,
      TAKE_MEM_ERROR = 3'b001,
      TAKE_INSTR_ERROR = 3'b010,
      TAKE_MID = 3'b011,
      TAKE_LOW = 3'b100
   } take_type;
endpackage

// *** core/two_level_interrupt_unit.sv ***
// Two-level interrupt unit with a classic Wishbone register slave
`timescale 1ns/1ps
module two_level_interrupt_unit #(
   parameter bit VARIANT_32 = 1'b1,
   parameter bit EXT_LINES = 1'b1,
   parameter logic [31:0] CONFIG_BASE = 32'h0000_0000
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic [31:0] irq_i,
   input wire logic mem_error_i,
   input wire logic instr_error_i,
   input wire logic [31:0] next_pc_i,
   input wire logic flag_we_i,
   input wire logic [1:0] flag_enables_i,
   output logic redirect_o,
   output logic [31:0] vector_addr_o,
   output logic [31:0] status_o
);

   // Architectural registers
   logic [31:0] vector_base;
   logic [31:0] trigger_mode_register;
   logic [31:0] level_assign_register;
   logic [31:0] processor_status_word;
   logic [31:0] low_level_return_link;
   logic [31:0] mid_level_return_link;
   logic [31:0] low_level_status_save;
   logic [31:0] mid_level_status_save;
   logic [31:0] pulse_pending;
   // Line sampling
   logic [31:0] irq_meta;
   logic [31:0] irq_sync;
   logic [31:0] irq_prev;
   // Decision signals
   logic [31:0] lines_present;
   logic [31:0] request;
   logic [31:0] mid_req;
   logic [31:0] low_req;
   logic [5:0] mid_pick;
   logic [5:0] low_pick;
   logic [31:0] vector_config_register;
   logic [31:0] next_status;
   logic [4:0] take_vec;
   logic bus_req;
   logic bus_wr;
   irq_unit_pkg::take_type take;
   logic base_load;

   // Winner of a set: {found, line}
   function automatic logic [5:0] pick_winner(input logic [31:0] req, input logic v32);
      logic [5:0] res;
      res = 6'h00;
      for (int i = 0; i < 32; i++) begin
         if (v32) begin
            if (req[i] && !res[5]) begin
               res = {1'b1, 5'(i)};
            end
         end else if (req[i]) begin
            res = {1'b1, 5'(i)};
         end
      end
      if (!v32 && req[irq_unit_pkg::TOP_LINE_16]) begin
         res = {1'b1, irq_unit_pkg::TOP_LINE_16};
      end
      return res;
   endfunction

   // Configuration word, read only
   assign vector_config_register = (CONFIG_BASE & irq_unit_pkg::CFG_BASE_MASK)
      | (32'(VARIANT_32) << irq_unit_pkg::CFG_VARIANT_BIT)
      | (32'(EXT_LINES) << irq_unit_pkg::CFG_EXT_BIT);

   // Implemented lines per variant
   assign lines_present = VARIANT_32 ? irq_unit_pkg::LINES_32 :
      (EXT_LINES ? (irq_unit_pkg::LINES_16 | irq_unit_pkg::LINES_EXT)
                 : irq_unit_pkg::LINES_16);

   // Line synchroniser, two stages
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_meta <= 32'h0000_0000;
         irq_sync <= 32'h0000_0000;
      end else begin
         irq_meta <= irq_i;
         irq_sync <= irq_meta;
      end
   end

   // Edge history for pulse lines
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_prev <= 32'h0000_0000;
      end else begin
         irq_prev <= irq_sync;
      end
   end

   // Pulse pending latch; a new edge beats the clear of a take
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pulse_pending <= 32'h0000_0000;
      end else begin
         for (int i = 0; i < 32; i++) begin
            if (irq_sync[i] && !irq_prev[i]) begin
               pulse_pending[i] <= 1'b1;
            end else if ((take == irq_unit_pkg::TAKE_MID || take == irq_unit_pkg::TAKE_LOW)
                         && take_vec == 5'(i)) begin
               pulse_pending[i] <= 1'b0;
            end
         end
      end
   end

   // Requests split by trigger mode and level set
   assign request = lines_present & ((trigger_mode_register & pulse_pending)
      | (~trigger_mode_register & irq_sync));
   assign mid_req = request & level_assign_register;
   assign low_req = request & ~level_assign_register;
   assign mid_pick = pick_winner(mid_req, VARIANT_32);
   assign low_pick = pick_winner(low_req, VARIANT_32);

   // Entry choice: exceptions, then level 2, then level 1
   always_comb begin
      take = irq_unit_pkg::TAKE_NONE;
      take_vec = 5'h00;
      if (mem_error_i) begin
         take = irq_unit_pkg::TAKE_MEM_ERROR;
         take_vec = irq_unit_pkg::VEC_MEM_ERROR;
      end else if (instr_error_i) begin
         take = irq_unit_pkg::TAKE_INSTR_ERROR;
         take_vec = irq_unit_pkg::VEC_INSTR_ERROR;
      end else if (mid_pick[5] && processor_status_word[irq_unit_pkg::MID_SET_ENABLE_BIT]
                   && !processor_status_word[irq_unit_pkg::MID_ACTIVE_BIT]) begin
         take = irq_unit_pkg::TAKE_MID;
         take_vec = mid_pick[4:0];
      end else if (low_pick[5] && processor_status_word[irq_unit_pkg::LOW_SET_ENABLE_BIT]
                   && !processor_status_word[irq_unit_pkg::LOW_ACTIVE_BIT]
                   && !processor_status_word[irq_unit_pkg::MID_ACTIVE_BIT]) begin
         take = irq_unit_pkg::TAKE_LOW;
         take_vec = low_pick[4:0];
      end
   end

   // Bus strobes
   assign bus_req = cyc_i && stb_i && !ack_o;
   assign bus_wr = bus_req && we_i && (sel_i == 4'hf);

   // Status word after entry: level 1 drops only its own enable, others drop both; active bit raised except on exceptions
   always_comb begin
      next_status = processor_status_word;
      case (take)
         irq_unit_pkg::TAKE_MEM_ERROR, irq_unit_pkg::TAKE_INSTR_ERROR: begin
            next_status[irq_unit_pkg::MID_SET_ENABLE_BIT] = 1'b0;
            next_status[irq_unit_pkg::LOW_SET_ENABLE_BIT] = 1'b0;
         end
         irq_unit_pkg::TAKE_MID: begin
            next_status[irq_unit_pkg::MID_SET_ENABLE_BIT] = 1'b0;
            next_status[irq_unit_pkg::LOW_SET_ENABLE_BIT] = 1'b0;
            next_status[irq_unit_pkg::MID_ACTIVE_BIT] = 1'b1;
         end
         irq_unit_pkg::TAKE_LOW: begin
            next_status[irq_unit_pkg::LOW_SET_ENABLE_BIT] = 1'b0;
            next_status[irq_unit_pkg::LOW_ACTIVE_BIT] = 1'b1;
         end
         default: begin
            next_status = processor_status_word;
         end
      endcase
   end

   // Status word: entry wins over flag update and bus write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         processor_status_word <= irq_unit_pkg::RESET_STATUS_WORD;
      end else if (take != irq_unit_pkg::TAKE_NONE) begin
         processor_status_word <= next_status;
      end else if (flag_we_i) begin
         processor_status_word[irq_unit_pkg::LOW_SET_ENABLE_BIT] <= flag_enables_i[0];
         processor_status_word[irq_unit_pkg::MID_SET_ENABLE_BIT] <= flag_enables_i[1];
      end else if (bus_wr && adr_i == irq_unit_pkg::OFF_STATUS_WORD) begin
         processor_status_word <= dat_i;
      end
   end

   // Mid link pair: level 2 and both error exceptions
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mid_level_return_link <= 32'h0000_0000;
         mid_level_status_save <= 32'h0000_0000;
      end else if (take == irq_unit_pkg::TAKE_MID || take == irq_unit_pkg::TAKE_MEM_ERROR
                   || take == irq_unit_pkg::TAKE_INSTR_ERROR) begin
         mid_level_return_link <= next_pc_i;
         mid_level_status_save <= processor_status_word;
      end else if (bus_wr && adr_i == irq_unit_pkg::OFF_MID_LINK) begin
         mid_level_return_link <= dat_i;
      end else if (bus_wr && adr_i == irq_unit_pkg::OFF_MID_STATUS_SAVE) begin
         mid_level_status_save <= dat_i;
      end
   end

   // Low link pair: level 1 only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         low_level_return_link <= 32'h0000_0000;
         low_level_status_save <= 32'h0000_0000;
      end else if (take == irq_unit_pkg::TAKE_LOW) begin
         low_level_return_link <= next_pc_i;
         low_level_status_save <= processor_status_word;
      end else if (bus_wr && adr_i == irq_unit_pkg::OFF_LOW_LINK) begin
         low_level_return_link <= dat_i;
      end else if (bus_wr && adr_i == irq_unit_pkg::OFF_LOW_STATUS_SAVE) begin
         low_level_status_save <= dat_i;
      end
   end

   // Redirect of the program counter into the vector slot
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         redirect_o <= 1'b0;
         vector_addr_o <= 32'h0000_0000;
      end else begin
         redirect_o <= (take != irq_unit_pkg::TAKE_NONE);
         if (take != irq_unit_pkg::TAKE_NONE) begin
            vector_addr_o <= vector_base + ({27'h0, take_vec} << irq_unit_pkg::SLOT_SHIFT);
         end
      end
   end

   // Vector base: reset from configuration, relocatable by write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vector_base <= 32'h0000_0000;
      end else if (bus_wr && adr_i == irq_unit_pkg::OFF_VEC_BASE) begin
         vector_base <= dat_i & irq_unit_pkg::CFG_BASE_MASK;
      end else if (base_load) begin
         vector_base <= vector_config_register & irq_unit_pkg::CFG_BASE_MASK;
      end
   end

   // First cycle after reset release loads the configured base
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         base_load <= 1'b1;
      end else begin
         base_load <= 1'b0;
      end
   end

   // Trigger mode and level assignment
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trigger_mode_register <= irq_unit_pkg::RESET_TRIGGER_MODE;
         level_assign_register <= VARIANT_32 ? irq_unit_pkg::RESET_LEVEL_32
                                             : irq_unit_pkg::RESET_LEVEL_16;
      end else if (bus_wr && adr_i == irq_unit_pkg::OFF_TRIGGER_MODE) begin
         if (VARIANT_32) begin
            trigger_mode_register <= dat_i & irq_unit_pkg::LINES_32;
         end
      end else if (bus_wr && adr_i == irq_unit_pkg::OFF_LEVEL_ASSIGN) begin
         level_assign_register <= dat_i & lines_present;
      end
   end

   // Wishbone acknowledge and read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= bus_req;
         if (bus_req && !we_i) begin
            case (adr_i)
               irq_unit_pkg::OFF_VEC_CONFIG: dat_o <= vector_config_register;
               irq_unit_pkg::OFF_VEC_BASE: dat_o <= vector_base;
               irq_unit_pkg::OFF_TRIGGER_MODE: dat_o <= trigger_mode_register;
               irq_unit_pkg::OFF_LEVEL_ASSIGN: dat_o <= level_assign_register;
               irq_unit_pkg::OFF_STATUS_WORD: dat_o <= processor_status_word;
               irq_unit_pkg::OFF_LOW_LINK: dat_o <= low_level_return_link;
               irq_unit_pkg::OFF_MID_LINK: dat_o <= mid_level_return_link;
               irq_unit_pkg::OFF_LOW_STATUS_SAVE: dat_o <= low_level_status_save;
               irq_unit_pkg::OFF_MID_STATUS_SAVE: dat_o <= mid_level_status_save;
               irq_unit_pkg::OFF_PENDING: dat_o <= request;
               default: dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign status_o = processor_status_word;

   // Checks
   sequence mid_entry_seq;
      take == irq_unit_pkg::TAKE_MID;
   endsequence

   sequence exc_entry_seq;
      mem_error_i || instr_error_i;
   endsequence

   sequence low_entry_seq;
      take == irq_unit_pkg::TAKE_LOW;
   endsequence

   AST_EXC_DISABLE: assert property (@(posedge clk_i) disable iff (rst_i)
      exc_entry_seq |=> !status_o[irq_unit_pkg::MID_SET_ENABLE_BIT]
         && !status_o[irq_unit_pkg::LOW_SET_ENABLE_BIT] && redirect_o)
      else $error("exception left interrupts enabled");

   AST_EXC_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
      mem_error_i |=> vector_addr_o == $past(vector_base) + 32'h0000_0008)
      else $error("memory error not sent to its slot");

   AST_MID_SAVE: assert property (@(posedge clk_i) disable iff (rst_i)
      mid_entry_seq |=> mid_level_return_link == $past(next_pc_i)
         && mid_level_status_save == $past(status_o))
      else $error("mid link pair not saved");

   AST_LOW_SAVE: assert property (@(posedge clk_i) disable iff (rst_i)
      low_entry_seq |=> low_level_return_link == $past(next_pc_i)
         && $stable(mid_level_return_link))
      else $error("low link pair not saved");

   AST_MID_OVER_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
      (mid_pick[5] && low_pick[5] && !mem_error_i && !instr_error_i
         && status_o[irq_unit_pkg::MID_SET_ENABLE_BIT]
         && !status_o[irq_unit_pkg::MID_ACTIVE_BIT]) |-> take == irq_unit_pkg::TAKE_MID)
      else $error("level 1 beat level 2");

   AST_LOW_BLOCKED: assert property (@(posedge clk_i) disable iff (rst_i)
      !status_o[irq_unit_pkg::LOW_SET_ENABLE_BIT] |-> take != irq_unit_pkg::TAKE_LOW)
      else $error("level 1 taken while disabled");

   AST_VEC_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
      take != irq_unit_pkg::TAKE_NONE |=> redirect_o
         && vector_addr_o == $past(vector_base) + {24'h0, $past(take_vec), 3'b000})
      else $error("vector address wrong");

   AST_IRQ7_TOP: assert property (@(posedge clk_i) disable iff (rst_i)
      (!VARIANT_32 && mid_req[7]) |-> mid_pick == 6'h27)
      else $error("line 7 lost its top rank");

   AST_LOW_ORDER: assert property (@(posedge clk_i) disable iff (rst_i)
      (VARIANT_32 && low_req[9:0] == 10'h220) |-> low_pick == 6'h25)
      else $error("lower line lost to higher line");

   AST_IRQ7_TOP_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
      (!VARIANT_32 && low_req[7]) |-> low_pick == 6'h27)
      else $error("line 7 lost its top rank in level 1");

   AST_LINE31_TOP: assert property (@(posedge clk_i) disable iff (rst_i)
      (!VARIANT_32 && EXT_LINES && !low_req[7] && low_req[31]) |-> low_pick == 6'h3f)
      else $error("line 31 lost its top level 1 rank");

   AST_BASE_RESET: assert property (@(posedge clk_i)
      $fell(rst_i) ##1 1'b1 |-> vector_base == (CONFIG_BASE & irq_unit_pkg::CFG_BASE_MASK)
         || $past(bus_wr))
      else $error("vector base not loaded at reset");

   AST_WB_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_req |=> ack_o ##1 !ack_o)
      else $error("bus acknowledge not one cycle");

endmodule // two_level_interrupt_unit

// *** tb/core_model.sv ***
// Behavioural core pipeline that follows the unit's redirects
`timescale 1ns/1ps
module core_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic redirect_i,
   input wire logic [31:0] vector_addr_i,
   output logic [31:0] next_pc_o
);
   // Program counter holds, then jumps into the vector slot on a redirect
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         next_pc_o <= 32'h0000_1000;
      end else if (redirect_i) begin
         next_pc_o <= vector_addr_i + 32'h0000_0004;
      end
   end
endmodule // core_model

// *** tb/two_level_interrupt_unit_tb.sv ***
// Self-checking testbench of the two-level interrupt unit
`timescale 1ns/1ps
module two_level_interrupt_unit_tb;
   localparam logic [31:0] CFG_BASE = 32'h0001_0400;
   localparam logic [31:0] NEW_BASE = 32'h0002_0000;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic ack_o;
   logic [31:0] irq_i = 32'h0;
   logic mem_error_i = 1'b0;
   logic instr_error_i = 1'b0;
   logic [31:0] next_pc_i;
   logic flag_we_i = 1'b0;
   logic [1:0] flag_enables_i = 2'b00;
   logic redirect_o;
   logic [31:0] vector_addr_o;
   logic [31:0] status_o;
   logic [31:0] rd;
   logic [31:0] pc_seen;
   logic [31:0] last_vec = 32'h0;
   logic [31:0] irq16 = 32'h0;
   logic redirect16;
   logic [31:0] vec16;
   logic [31:0] last_vec16 = 32'h0;
   int takes = 0;
   int mark;
   int num_errors = 0;
   int compares = 0;

   // Core clock, 25 ns period
   always #12.5 clk_i = ~clk_i;

   two_level_interrupt_unit #(.VARIANT_32(1'b1), .EXT_LINES(1'b1), .CONFIG_BASE(CFG_BASE)) u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .irq_i(irq_i), .mem_error_i(mem_error_i), .instr_error_i(instr_error_i),
      .next_pc_i(next_pc_i), .flag_we_i(flag_we_i), .flag_enables_i(flag_enables_i),
      .redirect_o(redirect_o), .vector_addr_o(vector_addr_o), .status_o(status_o)
   );

   // Second unit in the 16-plus-16 variant, sharing bus, flags and exceptions
   two_level_interrupt_unit #(.VARIANT_32(1'b0), .EXT_LINES(1'b1), .CONFIG_BASE(CFG_BASE))
      u_dut16 (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(), .ack_o(),
      .irq_i(irq16), .mem_error_i(mem_error_i), .instr_error_i(instr_error_i),
      .next_pc_i(next_pc_i), .flag_we_i(flag_we_i), .flag_enables_i(flag_enables_i),
      .redirect_o(redirect16), .vector_addr_o(vec16), .status_o()
   );

   core_model u_core (
      .clk_i(clk_i), .rst_i(rst_i), .redirect_i(redirect_o),
      .vector_addr_i(vector_addr_o), .next_pc_o(next_pc_i)
   );

   // Record every redirect, so none is missed while the bus is busy
   always @(posedge clk_i) begin
      if (redirect_o === 1'b1) begin
         takes <= takes + 1;
         last_vec <= vector_addr_o;
      end
      if (redirect16 === 1'b1) begin
         last_vec16 <= vec16;
      end
   end

   task automatic check32(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Classic single Wishbone cycle, held until ack is sampled
   task automatic bus(input logic w, input logic [7:0] adr, input logic [31:0] wd,
         output logic [31:0] rdat);
      int n;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= adr;
      sel_i <= 4'hf;
      dat_i <= wd;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_i);
         if (ack_o === 1'b1) break;
      end
      rdat = dat_o;
      if (n == 50) check32("bus ack", 32'h1, 32'h0);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i);
   endtask

   // Flag-update strobe carrying both set enables
   task automatic set_flags(input logic [1:0] en);
      flag_we_i <= 1'b1;
      flag_enables_i <= en;
      @(posedge clk_i);
      flag_we_i <= 1'b0;
      @(posedge clk_i);
   endtask

   // Bounded wait for a redirect past the mark, then compare its vector
   task automatic wait_take(input string name, input logic [31:0] exp);
      for (int n = 0; n < 20; n++) begin
         @(posedge clk_i);
         if (takes != mark) break;
      end
      check32(name, exp, last_vec);
   endtask

   task automatic end_sim();
      $display("num_errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check32("status reset", 32'h0, status_o);
      bus(1'b0, irq_unit_pkg::OFF_VEC_CONFIG, 32'h0, rd);
      check32("config", CFG_BASE | 32'h3, rd);
      bus(1'b1, irq_unit_pkg::OFF_VEC_CONFIG, 32'hffff_ffff, rd);
      bus(1'b0, irq_unit_pkg::OFF_VEC_CONFIG, 32'h0, rd);
      check32("config kept", CFG_BASE | 32'h3, rd);
      bus(1'b0, irq_unit_pkg::OFF_VEC_BASE, 32'h0, rd);
      check32("base at reset", CFG_BASE, rd);
      bus(1'b0, 8'h3c, 32'h0, rd);
      check32("unmapped", 32'h0, rd);
      bus(1'b1, irq_unit_pkg::OFF_VEC_BASE, NEW_BASE, rd);
      bus(1'b0, irq_unit_pkg::OFF_VEC_BASE, 32'h0, rd);
      check32("base moved", NEW_BASE, rd);
      // Two level 1 lines at once, lower number first
      set_flags(2'b11);
      check32("enables", 32'h6, status_o & 32'h1e);
      pc_seen = next_pc_i;
      mark = takes;
      irq_i <= 32'h0000_0220;
      wait_take("vector 5", NEW_BASE + 32'h28);
      check32("low entry status", 32'h0c, status_o & 32'h1e);
      bus(1'b0, irq_unit_pkg::OFF_LOW_LINK, 32'h0, rd);
      check32("low link", pc_seen, rd);
      bus(1'b0, irq_unit_pkg::OFF_LOW_STATUS_SAVE, 32'h0, rd);
      check32("low save", 32'h6, rd & 32'h1e);
      // Line 9 moved to level 2 preempts the running level 1 handler
      pc_seen = next_pc_i;
      mark = takes;
      bus(1'b1, irq_unit_pkg::OFF_LEVEL_ASSIGN, 32'h0000_0200, rd);
      wait_take("vector 9", NEW_BASE + 32'h48);
      check32("mid entry status", 32'h18, status_o & 32'h1e);
      bus(1'b0, irq_unit_pkg::OFF_MID_LINK, 32'h0, rd);
      check32("mid link", pc_seen, rd);
      bus(1'b0, irq_unit_pkg::OFF_MID_STATUS_SAVE, 32'h0, rd);
      check32("mid save", 32'h0c, rd & 32'h1e);
      irq_i <= 32'h0;
      // Both exceptions, taken with every interrupt masked
      for (int k = 1; k < 3; k++) begin
         pc_seen = next_pc_i;
         mark = takes;
         {instr_error_i, mem_error_i} <= 2'(k);
         @(posedge clk_i);
         {instr_error_i, mem_error_i} <= 2'b00;
         wait_take("exception", NEW_BASE + 32'(k * 8));
         bus(1'b0, irq_unit_pkg::OFF_MID_LINK, 32'h0, rd);
         check32("exception link", pc_seen, rd);
      end
      // Line 20 held while both sets are disabled
      bus(1'b1, irq_unit_pkg::OFF_STATUS_WORD, 32'h0, rd);
      mark = takes;
      irq_i <= 32'h0010_0000;
      repeat (8) @(posedge clk_i);
      check32("masked", 32'(mark), 32'(takes));
      bus(1'b0, irq_unit_pkg::OFF_PENDING, 32'h0, rd);
      check32("pending", 32'h0010_0000, rd);
      set_flags(2'b01);
      wait_take("vector 20", NEW_BASE + 32'ha0);
      irq_i <= 32'h0;
      // Pulse on line 4 kept while masked, taken once enabled
      bus(1'b1, irq_unit_pkg::OFF_STATUS_WORD, 32'h0, rd);
      bus(1'b1, irq_unit_pkg::OFF_TRIGGER_MODE, 32'h0000_0010, rd);
      mark = takes;
      irq_i <= 32'h0000_0010;
      @(posedge clk_i);
      irq_i <= 32'h0;
      repeat (6) @(posedge clk_i);
      set_flags(2'b01);
      wait_take("pulse line 4", NEW_BASE + 32'h20);
      // 16-plus-16 unit: line 31 tops level 1, line 7 beats it in the same set
      irq16 <= 32'h8010_0000;
      repeat (6) @(posedge clk_i);
      check32("line 31 top", NEW_BASE + 32'hf8, last_vec16);
      irq16 <= 32'h8000_0080;
      repeat (3) @(posedge clk_i);
      bus(1'b1, irq_unit_pkg::OFF_STATUS_WORD, 32'h2, rd);
      repeat (3) @(posedge clk_i);
      check32("line 7 top", NEW_BASE + 32'h38, last_vec16);
      end_sim();
   end

   // Watchdog well beyond the length of the sequence
   initial begin
      #(25 * 4000);
      num_errors++;
      end_sim();
   end
endmodule // two_level_interrupt_unit_tb
